// ---- rtl/tsdms_map.svh ----
`ifndef TSDMS_MAP_SVH
`define TSDMS_MAP_SVH
// ==========================================================
// serial frame layout
`define TSDMS_FRAME_BITS 5'd24
`define TSDMS_HDR_BITS 5'd8
`define TSDMS_RD_BIT 7
// ==========================================================
// register addresses (7-bit)
`define TSDMS_ADDR_SUPPLY1 7'h01
`define TSDMS_ADDR_CONFIG 7'h02
`define TSDMS_ADDR_DIAG 7'h07
`define TSDMS_ADDR_ALARM 7'h44
// ==========================================================
// supply control 1 fields
`define TSDMS_RUN_BIT 13
// ==========================================================
// config fields and reset
`define TSDMS_CFG_THR_LO 0
`define TSDMS_CFG_THR_HI 1
`define TSDMS_CFG_LATCH_BIT 2
`define TSDMS_CFG_RANGE_LO 3
`define TSDMS_CFG_RANGE_HI 5
`define TSDMS_CFG_PDN_BIT 6
`define TSDMS_CFG_SCALE_BIT 7
`define TSDMS_CFG_IGAIN_BIT 8
`define TSDMS_CFG_TRI_BIT 9
`define TSDMS_CFG_RESET 16'h0007
// ==========================================================
// diagnostic fields and reset
`define TSDMS_DIAG_ROUTE_LO 12
`define TSDMS_DIAG_ROUTE_HI 15
`define TSDMS_DIAG_DIODE_LO 0
`define TSDMS_DIAG_DIODE_HI 4
`define TSDMS_DIAG_RESET 16'h0000
// ==========================================================
// alarm status fields
`define TSDMS_ALM_FLAG_BIT 0
`define TSDMS_ALM_LIVE_BIT 1
// ==========================================================
// trip thresholds in degrees celsius
`define TSDMS_THR_100 8'd100
`define TSDMS_THR_110 8'd110
`define TSDMS_THR_120 8'd120
`define TSDMS_THR_130 8'd130
// range codes that select the high current stages
`define TSDMS_RANGE_STAGE_A 3'd5
`define TSDMS_RANGE_STAGE_B 3'd6
`endif

// ---- rtl/tsdms_pkg.sv ----
package tsdms_pkg;
  // active power stage watched by the shutdown comparator
  typedef enum logic [1:0] {
    TSDMS_STAGE_A,
    TSDMS_STAGE_B
  } tsdms_stage_type;
  // serial frame phase
  typedef enum logic [1:0] {
    TSDMS_IDLE,
    TSDMS_HEADER,
    TSDMS_PAYLOAD
  } tsdms_phase_type;
endpackage

// ---- rtl/tsdms_thermal_measure.sv ----
`timescale 1ns/1ns
`include "tsdms_map.svh"
module tsdms_thermal_measure
  import tsdms_pkg::*;
(
  input wire logic clock, // 125 MHz system clock
  input wire logic rst_n, // synchronous reset, active low
  input wire logic sclk, // serial clock pin
  input wire logic sync_n, // serial frame select pin, active low
  input wire logic sdi, // serial data in pin
  output logic sdo, // serial data out
  output logic sdo_oe, // serial data out drive enable
  input wire logic [7:0] stage_a_trip_segment_temp, // stage a sensor, deg C
  input wire logic [7:0] stage_b_trip_segment_temp, // stage b sensor, deg C
  output logic force_stage_run, // force amplifier stage enabled
  output logic overtemp_alarm_pin, // alarm pin output level (always 0)
  output logic overtemp_alarm_oe, // alarm pin pulled low when high
  output logic [4:0] spare_output_pin_diode, // diode on spare pin, 0 none
  output logic [3:0] measure_route, // measure output source select
  output logic measure_output_oe, // measure output driver enabled
  output logic output_scale_select, // 0 gain 1, 1 gain 0.2
  output logic current_gain_select, // 0 gain 20, 1 gain 10
  output logic power_down // device in power-down
);

  // ==========================================================
  // pin synchronisers
  logic [2:0] sclk_s_r, sync_s_r, sdi_s_r;
  logic sclk_f_r, sync_f_r, sdi_f_r, sclk_d_r;

  // three stages; a change counts once stages two and three agree
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      sclk_s_r <= 3'h0;
      sync_s_r <= 3'h7;
      sdi_s_r <= 3'h0;
    end else begin
      sclk_s_r <= {sclk_s_r[1:0], sclk};
      sync_s_r <= {sync_s_r[1:0], sync_n};
      sdi_s_r <= {sdi_s_r[1:0], sdi};
    end
  end

  // filtered levels hold their value while the stages disagree
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      sclk_f_r <= 1'b0;
      sync_f_r <= 1'b1;
      sdi_f_r <= 1'b0;
      sclk_d_r <= 1'b0;
    end else begin
      if (sclk_s_r[1] == sclk_s_r[2]) sclk_f_r <= sclk_s_r[2];
      if (sync_s_r[1] == sync_s_r[2]) sync_f_r <= sync_s_r[2];
      if (sdi_s_r[1] == sdi_s_r[2]) sdi_f_r <= sdi_s_r[2];
      sclk_d_r <= sclk_f_r;
    end
  end

  logic sclk_rise, sclk_fall, in_frame;
  assign in_frame = !sync_f_r;
  assign sclk_rise = in_frame && sclk_f_r && !sclk_d_r;
  assign sclk_fall = in_frame && !sclk_f_r && sclk_d_r;

  // ==========================================================
  // serial frame engine
  tsdms_phase_type phase_r;
  logic [4:0] bit_cnt_r;
  logic [23:0] shift_r;
  logic [23:0] shift_nxt;
  logic [15:0] rd_shift_r;
  logic hdr_done, frame_done, is_read;
  logic [6:0] hdr_addr;

  assign shift_nxt = {shift_r[22:0], sdi_f_r};
  assign hdr_done = sclk_rise && (bit_cnt_r == `TSDMS_HDR_BITS - 5'd1);
  assign frame_done = sclk_rise && (bit_cnt_r == `TSDMS_FRAME_BITS - 5'd1);
  assign is_read = shift_nxt[`TSDMS_RD_BIT];
  assign hdr_addr = shift_nxt[6:0];

  // phase and bit count; a frame cut short by sync_n is dropped
  always_ff @(posedge clock) begin
    if (!rst_n || !in_frame) begin
      phase_r <= TSDMS_IDLE;
      bit_cnt_r <= 5'd0;
      shift_r <= 24'h000000;
    end else begin
      case (phase_r)
        TSDMS_IDLE: begin
          phase_r <= TSDMS_HEADER;
        end
        TSDMS_HEADER: begin
          if (hdr_done) phase_r <= TSDMS_PAYLOAD;
        end
        TSDMS_PAYLOAD: begin
          if (frame_done) phase_r <= TSDMS_IDLE;
        end
        default: phase_r <= TSDMS_IDLE;
      endcase
      if (sclk_rise) begin
        shift_r <= shift_nxt;
        bit_cnt_r <= frame_done ? 5'd0 : bit_cnt_r + 5'd1;
      end
    end
  end

  // ==========================================================
  // register file
  logic [15:0] config_r, diag_r;
  logic run_r, alarm_flag_r, overtemp_r;
  logic wr_en, rd_alarm;
  logic [6:0] wr_addr;

  assign wr_addr = shift_nxt[22:16];
  assign wr_en = frame_done && !shift_nxt[23];
  assign rd_alarm = hdr_done && is_read && (hdr_addr == `TSDMS_ADDR_ALARM);

  // configuration and diagnostic select registers
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      config_r <= `TSDMS_CFG_RESET;
      diag_r <= `TSDMS_DIAG_RESET;
    end else if (wr_en) begin
      if (wr_addr == `TSDMS_ADDR_CONFIG) begin
        config_r <= shift_nxt[15:0];
      end else if (wr_addr == `TSDMS_ADDR_DIAG) begin
        diag_r <= shift_nxt[15:0];
      end
    end
  end

  // run bit: a trip beats a software write in the same cycle, for safety
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      run_r <= 1'b0;
    end else if (overtemp_r) begin
      run_r <= 1'b0;
    end else if (wr_en && wr_addr == `TSDMS_ADDR_SUPPLY1) begin
      run_r <= shift_nxt[`TSDMS_RUN_BIT];
    end
  end

  // readback word for the header just received
  function automatic logic [15:0] read_word(input logic [6:0] a);
    logic [15:0] w;
    w = 16'h0000;
    if (a == `TSDMS_ADDR_SUPPLY1) begin
      w[`TSDMS_RUN_BIT] = run_r;
    end else if (a == `TSDMS_ADDR_CONFIG) begin
      w = config_r;
    end else if (a == `TSDMS_ADDR_DIAG) begin
      w = diag_r;
    end else if (a == `TSDMS_ADDR_ALARM) begin
      w[`TSDMS_ALM_FLAG_BIT] = alarm_flag_r;
      w[`TSDMS_ALM_LIVE_BIT] = overtemp_r;
    end
    return w;
  endfunction

  // read data loads at header end, shifts out msb first on falling sclk
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      rd_shift_r <= 16'h0000;
      sdo <= 1'b0;
    end else if (hdr_done) begin
      rd_shift_r <= is_read ? read_word(hdr_addr) : 16'h0000;
    end else if (sclk_fall && phase_r == TSDMS_PAYLOAD) begin
      sdo <= rd_shift_r[15];
      rd_shift_r <= {rd_shift_r[14:0], 1'b0};
    end
  end
  assign sdo_oe = in_frame;

  // ==========================================================
  // thermal shutdown comparator
  tsdms_stage_type stage;
  logic [7:0] thr, temp_sel;
  logic [2:0] range_code;
  logic latched_mode, trip;

  assign range_code = config_r[`TSDMS_CFG_RANGE_HI:`TSDMS_CFG_RANGE_LO];
  assign latched_mode = config_r[`TSDMS_CFG_LATCH_BIT];
  assign power_down = config_r[`TSDMS_CFG_PDN_BIT];

  // stage b only in its own range; everything else watches stage a
  assign stage = (range_code == `TSDMS_RANGE_STAGE_B) ?
                 TSDMS_STAGE_B : TSDMS_STAGE_A;
  assign temp_sel = (stage == TSDMS_STAGE_B) ?
                    stage_b_trip_segment_temp :
                    stage_a_trip_segment_temp;

  // threshold decode from the two select bits
  always_comb begin
    case (config_r[`TSDMS_CFG_THR_HI:`TSDMS_CFG_THR_LO])
      2'd0: thr = `TSDMS_THR_100;
      2'd1: thr = `TSDMS_THR_110;
      2'd2: thr = `TSDMS_THR_120;
      default: thr = `TSDMS_THR_130;
    endcase
  end

  // sensors are off in power-down, so the comparator cannot fire
  assign trip = !power_down && (temp_sel > thr);

  // registered comparator; latched flag set wins over the clearing read
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      overtemp_r <= 1'b0;
      alarm_flag_r <= 1'b0;
    end else begin
      overtemp_r <= trip;
      if (overtemp_r) alarm_flag_r <= 1'b1;
      else if (rd_alarm) alarm_flag_r <= 1'b0;
    end
  end

  // ==========================================================
  // outputs
  assign force_stage_run = run_r && !overtemp_r;
  assign overtemp_alarm_pin = 1'b0;
  // open drain: pulled low in either alarm mode; latched mode also shows a
  // live trip at once, so the pin does not wait a cycle for the flag
  assign overtemp_alarm_oe = latched_mode ? (alarm_flag_r || overtemp_r)
                                          : overtemp_r;
  assign spare_output_pin_diode =
    diag_r[`TSDMS_DIAG_DIODE_HI:`TSDMS_DIAG_DIODE_LO];
  assign measure_route =
    diag_r[`TSDMS_DIAG_ROUTE_HI:`TSDMS_DIAG_ROUTE_LO];
  assign measure_output_oe = !config_r[`TSDMS_CFG_TRI_BIT];
  assign output_scale_select = config_r[`TSDMS_CFG_SCALE_BIT];
  assign current_gain_select = config_r[`TSDMS_CFG_IGAIN_BIT];

endmodule // tsdms_thermal_measure

// ---- verif/tsdms_properties.sv ----
`timescale 1ns/1ns
module tsdms_properties (
  input wire logic clock, // system clock
  input wire logic rst_n, // sync reset, active low
  input wire logic sync_n, // frame select, active low
  input wire logic [7:0] stage_a_trip_segment_temp, // stage a temp
  input wire logic [7:0] stage_b_trip_segment_temp, // stage b temp
  input wire logic force_stage_run, // force stage enabled
  input wire logic overtemp_alarm_pin, // alarm data level
  input wire logic overtemp_alarm_oe, // alarm pull-down
  input wire logic [4:0] spare_output_pin_diode, // diode select
  input wire logic [3:0] measure_route, // measure source
  input wire logic measure_output_oe, // measure driver on
  input wire logic output_scale_select, // output scale
  input wire logic current_gain_select, // current gain
  input wire logic power_down // power-down
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);
  logic hot;
  logic cool;
  // both sensors over the top threshold trip whichever stage is active
  assign hot = stage_a_trip_segment_temp > 8'h82 &&
    stage_b_trip_segment_temp > 8'h82 && !power_down;
  assign cool = stage_a_trip_segment_temp <= 8'h64 &&
    stage_b_trip_segment_temp <= 8'h64;
  // ==========================================================
  // thermal protection
  chk_pin_low: assert property (overtemp_alarm_pin == 1'b0)
    else $error("alarm pin data not low");
  chk_trip_run: assert property (hot |=> !force_stage_run)
    else $error("force stage kept running when hot");
  chk_trip_alarm: assert property (hot |=> overtemp_alarm_oe)
    else $error("alarm not raised when hot");
  chk_pdn_quiet: assert property (power_down && $past(power_down) &&
    $past(power_down, 2) |-> !$rose(overtemp_alarm_oe))
    else $error("alarm rose in power-down");
  chk_cool_run: assert property ((sync_n && cool)[*8] |->
    !$fell(force_stage_run))
    else $error("run dropped below lowest threshold");
  chk_hot_alarm: assert property ((sync_n && hot)[*2] |->
    !$fell(overtemp_alarm_oe))
    else $error("alarm fell while hot");
  // ==========================================================
  // diag and measure outputs move only through register writes
  chk_diag_idle: assert property (sync_n[*8] |->
    $stable(measure_route) && $stable(spare_output_pin_diode))
    else $error("diag outputs moved without a frame");
  chk_cfg_idle: assert property (sync_n[*8] |->
    $stable({measure_output_oe, output_scale_select, current_gain_select}))
    else $error("measure outputs moved without a frame");
  cov_trip: cover property (hot ##1 !force_stage_run);
  cov_pdn: cover property (power_down && !overtemp_alarm_oe);
  cov_scale: cover property ($rose(output_scale_select));
endmodule // tsdms_properties

// ---- verif/tsdms_host_model.sv ----
`timescale 1ns/1ns
module tsdms_host_model (
  input wire logic clock, // pacing clock
  input wire logic sdo, // read data from device
  output logic sclk, // serial clock, still between frames
  output logic sync_n, // frame select, active low
  output logic sdi, // serial data to device
  output logic [15:0] rd_data, // last word read
  output logic rd_done // one-cycle pulse after a read
);
  initial begin
    sclk = 1'b0;
    sync_n = 1'b1;
    sdi = 1'b0;
    rd_data = 16'h0000;
    rd_done = 1'b0;
  end
  // wait n edges, then step just past the edge
  task automatic pace(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  // 24-bit frame, msb first; 5 clocks per half keeps the 4-clock minimum
  task automatic xfer(input logic rd, input logic [6:0] a,
                      input logic [15:0] d);
    logic [23:0] w;
    w = {rd, a, d};
    pace(1);
    sync_n = 1'b0;
    for (int i = 23; i >= 0; i--) begin
      sdi = w[i];
      pace(5);
      if (i < 16) rd_data[i] = sdo;
      sclk = 1'b1;
      pace(5);
      sclk = 1'b0;
    end
    pace(5);
    sync_n = 1'b1;
    sdi = ~sdi; // released line must not look like held data
    rd_done = rd;
    pace(1);
    rd_done = 1'b0;
    pace(6);
  endtask
endmodule // tsdms_host_model

// ---- verif/thermal_shutdown_measure_select_bench.sv ----
`timescale 1ns/1ns
`define CHK(a, b, m) begin \
  total_checks++; \
  if ((a) !== (b)) begin \
    errors++; \
    $display("[FAIL] %0t %s", $time, m); \
  end \
end
module thermal_shutdown_measure_select_bench;
  logic clock, rst_n, sdo, sdo_oe, sclk, sync_n, sdi;
  logic force_stage_run, overtemp_alarm_pin, overtemp_alarm_oe;
  logic measure_output_oe, output_scale_select, current_gain_select;
  logic power_down, rd_done;
  logic [7:0] stage_a_trip_segment_temp;
  logic [7:0] stage_b_trip_segment_temp;
  logic [7:0] thr;
  logic [4:0] spare_output_pin_diode;
  logic [3:0] measure_route;
  logic [15:0] rd_data, dg, c;
  logic [15:0] exp_q[$];
  int errors = 0, total_checks = 0;
  always #4 clock = ~clock;
  tsdms_thermal_measure u_dut (
    .clock(clock),
    .rst_n(rst_n),
    .sclk(sclk),
    .sync_n(sync_n),
    .sdi(sdi),
    .sdo(sdo),
    .sdo_oe(sdo_oe),
    .stage_a_trip_segment_temp(stage_a_trip_segment_temp),
    .stage_b_trip_segment_temp(stage_b_trip_segment_temp),
    .force_stage_run(force_stage_run),
    .overtemp_alarm_pin(overtemp_alarm_pin),
    .overtemp_alarm_oe(overtemp_alarm_oe),
    .spare_output_pin_diode(spare_output_pin_diode),
    .measure_route(measure_route),
    .measure_output_oe(measure_output_oe),
    .output_scale_select(output_scale_select),
    .current_gain_select(current_gain_select),
    .power_down(power_down)
  );
  tsdms_host_model u_host (
    .clock(clock),
    .sdo(sdo),
    .sclk(sclk),
    .sync_n(sync_n),
    .sdi(sdi),
    .rd_data(rd_data),
    .rd_done(rd_done)
  );
  task automatic wrap_up();
    if (errors == 0 && total_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic wr(input logic [6:0] a, input logic [15:0] d);
    u_host.xfer(1'b0, a, d);
  endtask
  task automatic rd(input logic [6:0] a, input logic [15:0] e);
    exp_q.push_back(e);
    u_host.xfer(1'b1, a, 16'h0000);
  endtask
  // each finished read is matched against the oldest note
  always @(posedge clock) begin
    if (rd_done) `CHK(rd_data, exp_q.pop_front(), "read data")
  end
  // a hung run is cut short and counted
  initial begin
    repeat (60000) @(posedge clock);
    errors++;
    wrap_up();
  end
  initial begin
    clock = 1'b0;
    rst_n = 1'b0;
    stage_a_trip_segment_temp = 8'h14;
    stage_b_trip_segment_temp = 8'h14;
    void'($urandom(92667));
    repeat (8) @(posedge clock);
    #1 rst_n = 1'b1;
    u_host.pace(4);
    `CHK(sdo_oe, 1'b0, "sdo driven idle")
    rd(7'h02, 16'h0007);
    rd(7'h55, 16'h0000);
    // every threshold, unlatched then latched, with clear and rerun
    for (int t = 0; t < 8; t++) begin
      thr = 8'd100 + 8'd10 * t[1:0];
      wr(7'h02, {13'h0000, t[2], t[1:0]});
      wr(7'h01, 16'h2000);
      stage_a_trip_segment_temp = thr;
      u_host.pace(3);
      `CHK(force_stage_run, 1'b1, "tripped at threshold")
      stage_a_trip_segment_temp = thr + 8'd1;
      u_host.pace(3);
      `CHK(force_stage_run, 1'b0, "no trip")
      `CHK(overtemp_alarm_oe, 1'b1, "no alarm")
      stage_a_trip_segment_temp = 8'h14;
      u_host.pace(3);
      `CHK(overtemp_alarm_oe, t[2], "alarm mode")
      `CHK(force_stage_run, 1'b0, "run bit kept")
      rd(7'h01, 16'h0000);
      if (t[2]) rd(7'h44, 16'h0001);
      if (t[2]) rd(7'h44, 16'h0000);
      `CHK(overtemp_alarm_oe, 1'b0, "alarm not cleared")
      wr(7'h01, 16'h2000);
      `CHK(force_stage_run, 1'b1, "rerun refused")
    end
    // stage b range watches only stage b
    wr(7'h02, 16'h0030);
    wr(7'h01, 16'h2000);
    stage_a_trip_segment_temp = 8'($urandom_range(255, 131));
    u_host.pace(3);
    `CHK(force_stage_run, 1'b1, "stage a watched")
    stage_b_trip_segment_temp = 8'hC8;
    stage_a_trip_segment_temp = 8'hC8;
    u_host.pace(3);
    `CHK(force_stage_run, 1'b0, "stage b ignored")
    rd(7'h44, 16'h0003);
    wr(7'h02, 16'h0040);
    wr(7'h01, 16'h2000);
    u_host.pace(3);
    `CHK(power_down, 1'b1, "no power-down")
    `CHK(force_stage_run, 1'b1, "trip in power-down")
    `CHK(overtemp_alarm_oe, 1'b0, "alarm in power-down")
    stage_a_trip_segment_temp = 8'h14;
    stage_b_trip_segment_temp = 8'h14;
    // random diag routing and measure settings
    for (int k = 0; k < 4; k++) begin
      dg = 16'($urandom);
      c = 16'($urandom) & 16'h0380;
      wr(7'h07, dg);
      wr(7'h02, c);
      `CHK(spare_output_pin_diode, dg[4:0], "diode")
      `CHK(measure_route, dg[15:12], "route")
      `CHK(measure_output_oe, ~c[9], "tristate")
      `CHK(output_scale_select, c[7], "scale")
      `CHK(current_gain_select, c[8], "current gain")
    end
    `CHK(exp_q.size(), 0, "reads lost")
    wrap_up();
  end
endmodule // thermal_shutdown_measure_select_bench
bind tsdms_thermal_measure tsdms_properties u_chk (
  .clock(clock),
  .rst_n(rst_n),
  .sync_n(sync_n),
  .stage_a_trip_segment_temp(stage_a_trip_segment_temp),
  .stage_b_trip_segment_temp(stage_b_trip_segment_temp),
  .force_stage_run(force_stage_run),
  .overtemp_alarm_pin(overtemp_alarm_pin),
  .overtemp_alarm_oe(overtemp_alarm_oe),
  .spare_output_pin_diode(spare_output_pin_diode),
  .measure_route(measure_route),
  .measure_output_oe(measure_output_oe),
  .output_scale_select(output_scale_select),
  .current_gain_select(current_gain_select),
  .power_down(power_down)
);
